/* rtl/dac_channel.sv */
`timescale 1ns/1ps
`default_nettype none

module dac_channel (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// controls
	input  wire logic         load_input,
	input  wire logic         update_dac,
	input  wire logic         power_load,
	input  wire logic [1:0]   power_mode,
	input  wire logic [11:0]  code,
	// state
	output logic      [11:0]  input_code,
	output logic      [11:0]  dac_code,
	output logic      [1:0]   mode
);

	typedef struct packed {
		logic [11:0] inp;
		logic [11:0] dac;
		logic [1:0]  mode;
	} chan_state_t;

	chan_state_t st_reg;
	chan_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (load_input) begin
			st_next.inp = code;
		end
		// transfer sees the value written in this same frame
		if (update_dac) begin
			st_next.dac = load_input ? code : st_reg.inp;
		end
		if (power_load) begin
			st_next.mode = power_mode;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_reg <= '{inp: dac_cmd_pkg::CODE_RESET, dac: dac_cmd_pkg::CODE_RESET,
				mode: dac_cmd_pkg::MODE_RESET};
		end else begin
			st_reg <= st_next;
		end
	end

	assign input_code = st_reg.inp;
	assign dac_code   = st_reg.dac;
	assign mode       = st_reg.mode;

endmodule

`default_nettype wire

/* rtl/dac_cmd_pkg.sv */
package dac_cmd_pkg;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int            NUM_CH        = 8;
	localparam int            CODE_W        = 12;
	localparam int            CMD_HI        = 7;
	localparam int            CMD_LO        = 4;
	localparam int            ADDR_HI       = 3;
	localparam int            ADDR_LO       = 0;
	localparam int            MSB_NIBBLE_HI = 7;
	localparam int            MSB_NIBBLE_LO = 4;
	localparam int            MODE_HI       = 14;
	localparam int            MODE_LO       = 13;
	localparam int            SEL_HI        = 12;
	localparam int            SEL_LO        = 5;

	// ----------------------------------------
	// command codes and addresses
	// ----------------------------------------
	localparam logic [3:0]    CMD_WRITE_ALL = 4'h2;
	localparam logic [3:0]    CMD_POWER     = 4'h4;
	localparam logic [3:0]    ADDR_BCAST    = 4'hF;
	localparam int            ADDR_INVALID  = 3;

	// ----------------------------------------
	// power modes and termination codes
	// ----------------------------------------
	localparam logic [1:0]    PWR_ON        = 2'h0;
	localparam logic [1:0]    PWR_DOWN_1K   = 2'h1;
	localparam logic [1:0]    PWR_DOWN_100K = 2'h2;
	localparam logic [1:0]    PWR_DOWN_HIZ  = 2'h3;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [11:0]   CODE_RESET    = 12'h000;
	localparam logic [1:0]    MODE_RESET    = PWR_ON;

	// ----------------------------------------
	// frame assembly states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_CMD = 3'b001,
		ST_MSB = 3'b010,
		ST_LSB = 3'b100
	} frame_state_t;

endpackage

/* rtl/dac_write_update_and_power_cmds.sv */
// Notes on behaviour
// RL1 - A global-update write to channel 0..7 loads that input register, then moves all inputs to DACs.
// RL2 - A frame is a command byte, a data byte with bits 11..4, then a byte whose top nibble is bits 3..0.
// RL3 - A global-update write with address top bit set, except all ones, changes nothing.
// RL4 - A global-update write to the all-ones address loads all inputs and updates all DACs.
// RL5 - In the power command bits 14..13 pick the mode, bits 12..5 pick channels H..A; mode 0 powers on.
// RL6 - Mode 1 powers selected channels down with the low-value pull-down.
// RL7 - Mode 2 powers selected channels down with the high-value pull-down.
// RL8 - Mode 3 powers selected channels down with the output high impedance.
// RL9 - Channels not selected by a power command keep their power state and termination.
`timescale 1ns/1ps
`default_nettype none

module dac_write_update_and_power_cmds (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// byte stream from the serial bus controller
	input  wire logic         frame_start,
	input  wire logic         byte_valid,
	input  wire logic [7:0]   byte_data,
	input  wire logic         frame_stop,
	// channel state
	output logic      [95:0]  input_codes,
	output logic      [95:0]  dac_codes,
	output logic      [7:0]   powered_down,
	output logic      [7:0]   term_1k,
	output logic      [7:0]   term_100k,
	output logic      [7:0]   term_hiz,
	// frame status
	output logic              cmd_done,
	output logic              cmd_rejected
);

	localparam int N = dac_cmd_pkg::NUM_CH;
	localparam int W = dac_cmd_pkg::CODE_W;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		dac_cmd_pkg::frame_state_t fsm;
		logic [7:0]                cmd_byte;
		logic [7:0]                msb_byte;
		logic                      done;
		logic                      rejected;
	} ctl_state_t;

	ctl_state_t st_reg;
	ctl_state_t st_next;

	logic [3:0]   cmd_code;
	logic [3:0]   acc_addr;
	logic [15:0]  data_word;
	logic [W-1:0] wr_code;
	logic [1:0]   pwr_mode;
	logic [N-1:0] pwr_sel;
	logic         frame_done;
	logic         is_write_all;
	logic         is_power;
	logic         addr_bcast;
	logic         addr_bad;
	logic [N-1:0] chan_sel;
	logic [2:0]   chan_idx;
	logic [N-1:0] load_input;
	logic [N-1:0] power_load;
	logic         update_all;
	logic [1:0]   ch_mode [N];

	// ----------------------------------------
	// decode of a completed frame
	// ----------------------------------------
	assign cmd_code   = st_reg.cmd_byte[dac_cmd_pkg::CMD_HI:dac_cmd_pkg::CMD_LO];
	assign acc_addr   = st_reg.cmd_byte[dac_cmd_pkg::ADDR_HI:dac_cmd_pkg::ADDR_LO];
	assign data_word  = {st_reg.msb_byte, byte_data};
	assign wr_code    = {st_reg.msb_byte,
		byte_data[dac_cmd_pkg::MSB_NIBBLE_HI:dac_cmd_pkg::MSB_NIBBLE_LO]}; // RL2
	assign pwr_mode   = data_word[dac_cmd_pkg::MODE_HI:dac_cmd_pkg::MODE_LO]; // RL5
	assign pwr_sel    = data_word[dac_cmd_pkg::SEL_HI:dac_cmd_pkg::SEL_LO]; // RL5
	assign frame_done = (st_reg.fsm == dac_cmd_pkg::ST_LSB) && byte_valid && !frame_start; // RL2

	assign addr_bcast   = (acc_addr == dac_cmd_pkg::ADDR_BCAST);
	assign addr_bad     = acc_addr[dac_cmd_pkg::ADDR_INVALID] && !addr_bcast; // RL3
	assign chan_idx     = acc_addr[dac_cmd_pkg::ADDR_INVALID-1:dac_cmd_pkg::ADDR_LO];
	assign update_all   = is_write_all && !addr_bad; // RL1 RL3 RL4

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always_comb begin
		is_write_all = 1'b0;
		is_power     = 1'b0;
		if (frame_done) begin
			unique case (cmd_code)
				dac_cmd_pkg::CMD_WRITE_ALL: begin
					is_write_all = 1'b1;
				end
				dac_cmd_pkg::CMD_POWER: begin
					is_power = 1'b1;
				end
				default: begin
					// neighbouring commands are refused here
					is_write_all = 1'b0;
					is_power     = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// channel selection
	// ----------------------------------------
	always_comb begin
		chan_sel = '0;
		if (addr_bcast) begin
			chan_sel = '1; // RL4
		end else if (!addr_bad) begin
			chan_sel[chan_idx] = 1'b1; // RL1
		end
		load_input = update_all ? chan_sel : '0; // RL1 RL4
		power_load = is_power ? pwr_sel : '0; // RL9
	end

	// ----------------------------------------
	// frame assembly
	// ----------------------------------------
	always_comb begin
		st_next          = st_reg;
		st_next.done     = 1'b0;
		st_next.rejected = 1'b0;
		if (frame_start) begin
			st_next.fsm = dac_cmd_pkg::ST_CMD;
		end else if (byte_valid) begin
			unique case (st_reg.fsm)
				dac_cmd_pkg::ST_CMD: begin
					st_next.cmd_byte = byte_data;
					st_next.fsm      = dac_cmd_pkg::ST_MSB;
				end
				dac_cmd_pkg::ST_MSB: begin
					st_next.msb_byte = byte_data;
					st_next.fsm      = dac_cmd_pkg::ST_LSB;
				end
				dac_cmd_pkg::ST_LSB: begin
					// further byte pairs repeat the command
					st_next.fsm      = dac_cmd_pkg::ST_MSB;
					st_next.done     = update_all || is_power;
					st_next.rejected = !(update_all || is_power);
				end
				default: begin
					st_next.fsm = dac_cmd_pkg::ST_CMD;
				end
			endcase
		end else if (frame_stop) begin
			st_next.fsm = dac_cmd_pkg::ST_CMD;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_reg <= '{fsm: dac_cmd_pkg::ST_CMD, cmd_byte: '0, msb_byte: '0,
				done: 1'b0, rejected: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_ch
		dac_channel u_ch (
			.ref_clk    (ref_clk),
			.sys_rst    (sys_rst),
			.load_input (load_input[g]),
			.update_dac (update_all),
			.power_load (power_load[g]),
			.power_mode (pwr_mode),
			.code       (wr_code),
			.input_code (input_codes[g*W +: W]),
			.dac_code   (dac_codes[g*W +: W]),
			.mode       (ch_mode[g])
		);
	end

	// ----------------------------------------
	// output termination
	// ----------------------------------------
	always_comb begin
		powered_down = '0;
		term_1k      = '0;
		term_100k    = '0;
		term_hiz     = '0;
		for (int i = 0; i < N; i++) begin
			unique case (ch_mode[i])
				dac_cmd_pkg::PWR_ON: begin
					powered_down[i] = 1'b0; // RL5
				end
				dac_cmd_pkg::PWR_DOWN_1K: begin
					powered_down[i] = 1'b1;
					term_1k[i]      = 1'b1; // RL6
				end
				dac_cmd_pkg::PWR_DOWN_100K: begin
					powered_down[i] = 1'b1;
					term_100k[i]    = 1'b1; // RL7
				end
				dac_cmd_pkg::PWR_DOWN_HIZ: begin
					powered_down[i] = 1'b1;
					term_hiz[i]     = 1'b1; // RL8
				end
			endcase
		end
	end

	// ----------------------------------------
	// frame status
	// ----------------------------------------
	assign cmd_done     = st_reg.done;
	assign cmd_rejected = st_reg.rejected;

endmodule

`default_nettype wire

/* verif/bus_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bus_host_model (
	// clock
	input  wire logic       ref_clk,
	// byte stream
	output logic            frame_start,
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic            frame_stop
);
	initial begin
		frame_start = 1'b0;
		byte_valid = 1'b0;
		byte_data = 8'h00;
		frame_stop = 1'b0;
	end
	// start, three bytes back to back, stop; idle data is the inverse of the last byte
	task automatic send(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
		@(negedge ref_clk);
		frame_start = 1'b1;
		@(negedge ref_clk);
		frame_start = 1'b0;
		byte_valid = 1'b1;
		byte_data = c;
		@(negedge ref_clk);
		byte_data = h;
		@(negedge ref_clk);
		byte_data = l;
		@(negedge ref_clk);
		byte_valid = 1'b0;
		byte_data = ~l;
		frame_stop = 1'b1;
		@(negedge ref_clk);
		frame_stop = 1'b0;
	endtask
endmodule

`default_nettype wire

/* verif/dac_cmd_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module dac_cmd_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// byte stream
	input wire logic        frame_start,
	input wire logic        byte_valid,
	input wire logic [7:0]  byte_data,
	input wire logic        frame_stop,
	// state and status
	input wire logic [95:0] input_codes,
	input wire logic [95:0] dac_codes,
	input wire logic [7:0]  powered_down,
	input wire logic [7:0]  term_1k,
	input wire logic [7:0]  term_100k,
	input wire logic [7:0]  term_hiz,
	input wire logic        cmd_done,
	input wire logic        cmd_rejected
);
	// last three received bytes: command, high data, low data
	logic [23:0] hist_reg;
	logic [23:0] hist_next;
	always_comb hist_next = byte_valid ? {hist_reg[15:0], byte_data} : hist_reg;
	always_ff @(posedge ref_clk) hist_reg <= sys_rst ? 24'h000000 : hist_next;
	wire logic       wr  = cmd_done && hist_reg[23:20] == 4'h2;
	wire logic       pwr = cmd_done && hist_reg[23:20] == 4'h4;
	wire logic [7:0] sel = hist_reg[12:5];
	wire logic [1:0] md  = hist_reg[14:13];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_pwr(logic [1:0] m);
		pwr && md == m;
	endsequence
	AST_WRITE: assert property (wr && !hist_reg[19] |->
		input_codes[12*hist_reg[18:16] +: 12] == hist_reg[15:4]) else $error("write lost");
	AST_ALLDAC: assert property (wr |-> dac_codes == input_codes) else $error("no update");
	AST_BCAST: assert property (wr && hist_reg[19:16] == 4'hF |->
		input_codes == {8{hist_reg[15:4]}}) else $error("broadcast lost");
	AST_INVALID: assert property (cmd_rejected |-> $stable(input_codes) &&
		$stable(dac_codes) && $stable(powered_down)) else $error("rejected changed state");
	AST_PWR_ON: assert property (s_pwr(0) |-> (powered_down & sel) == 8'h00)
		else $error("not on");
	AST_PWR_1K: assert property (s_pwr(1) |-> (term_1k & sel) == sel) else $error("no 1k");
	AST_PWR_100K: assert property (s_pwr(2) |-> (term_100k & sel) == sel)
		else $error("no 100k");
	AST_PWR_HIZ: assert property (s_pwr(3) |-> (term_hiz & sel) == sel) else $error("no hiz");
	AST_UNSEL: assert property (pwr |-> ((powered_down ^ $past(powered_down)) & ~sel) == 8'h00)
		else $error("unselected channel changed");
endmodule

bind dac_write_update_and_power_cmds dac_cmd_checker u_chk (.*);

`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value %s expected %0h seen %0h", n, e, a); end end

module tb;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        frame_start, byte_valid, frame_stop, cmd_done, cmd_rejected;
	logic [7:0]  byte_data, powered_down, term_1k, term_100k, term_hiz;
	logic [95:0] input_codes, dac_codes;
	int          err_total = 0;
	int          num_checks = 0;
	logic [95:0] ex = '0;
	logic [1:0]  em [8] = '{default: 2'h0};
	logic [7:0]  pd, t1, t2, t3, sl;
	logic [11:0] cd;
	logic [15:0] pw;
	int          n_done = 0;
	int          n_rej = 0;

	always #20 ref_clk = ~ref_clk;

	// status pulses, counted while they stand
	always @(negedge ref_clk) begin
		if (cmd_done === 1'b1)
			n_done++;
		if (cmd_rejected === 1'b1)
			n_rej++;
	end

	bus_host_model u_bus_host_model (.*);
	dac_write_update_and_power_cmds u_dac_write_update_and_power_cmds (.*);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task pwr_chk;
		for (int i = 0; i < 8; i++) begin
			pd[i] = em[i] != 2'h0;
			t1[i] = em[i] == 2'h1;
			t2[i] = em[i] == 2'h2;
			t3[i] = em[i] == 2'h3;
		end
		`CHK("powered down", pd, powered_down)
		`CHK("1k", t1, term_1k)
		`CHK("100k", t2, term_100k)
		`CHK("hiz", t3, term_hiz)
	endtask

	initial begin
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		`CHK("codes after reset", 96'h0, input_codes | dac_codes)
		pwr_chk();
		for (int c = 0; c < 8; c++) begin
			cd = 12'h5A0 + 12'(c);
			u_bus_host_model.send(8'h20 + 8'(c), cd[11:4], {cd[3:0], 4'hF});
			ex[12*c +: 12] = cd;
			`CHK("input codes", ex, input_codes)
			`CHK("dac codes", ex, dac_codes)
		end
		$display("test channel writes done");
		u_bus_host_model.send(8'h2B, 8'hFF, 8'hF0);
		`CHK("codes after bad address", ex, dac_codes)
		`CHK("inputs after bad address", ex, input_codes)
		u_bus_host_model.send(8'h30, 8'hAB, 8'hC0);
		`CHK("codes after other command", ex, dac_codes)
		`CHK("inputs after other command", ex, input_codes)
		`CHK("rejected frames", 2, n_rej)
		$display("test bad address done");
		u_bus_host_model.send(8'h2F, 8'h12, 8'h3F);
		ex = {8{12'h123}};
		`CHK("broadcast", ex, dac_codes)
		`CHK("broadcast inputs", ex, input_codes)
		$display("test broadcast done");
		// modes 1, 2, 3, 0 over sliding selections leave older channels untouched
		for (int k = 0; k < 4; k++) begin
			sl = 8'h0F << k;
			pw = {1'b0, 2'(k + 1), sl, 5'h1F};
			u_bus_host_model.send(8'h40, pw[15:8], pw[7:0]);
			for (int i = 0; i < 8; i++)
				if (sl[i])
					em[i] = 2'(k + 1);
			pwr_chk();
		end
		$display("test power modes done");
		`CHK("accepted frames", 13, n_done)
		`CHK("rejected total", 2, n_rej)
		tally_and_finish();
	end

	// the tests need about 110 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
